// ==== hdl/param_table_params.svh ====
// Constants of the basic flash parameter table store
`ifndef PARAM_TABLE_PARAMS_SVH
`define PARAM_TABLE_PARAMS_SVH
// ==========================================
// Bus map
`define OFF_PTR_WORD 8'h0C
`define OFF_W30 8'h30
`define OFF_W34 8'h34
`define OFF_W38 8'h38
`define OFF_W3C 8'h3C
`define OFF_W40 8'h40
`define OFF_W44 8'h44
`define OFF_W48 8'h48
`define OFF_W4C 8'h4C
`define OFF_W50 8'h50
`define OFF_W54 8'h54
`define OFF_DB_END 8'h58
`define OFF_BYTE_ADDR 8'h80
`define OFF_BYTE_DATA 8'h84
`define OFF_REJECT_CNT 8'h88
`define OFF_VARIANT 8'h8C
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define RESP_DECERR 2'h3
`define BYTE_ADDR_RST 7'h30
`define BYTE_ADDR_MAX 7'h7F
`define REJECT_MAX 16'hFFFF
// ==========================================
// Table fields
`define PTR_ID_MSB 8'hFF
`define PTR_VALUE 24'h000030
`define RESERVED_BYTE 8'hFF
`define MIN_ERASE_4K 2'h1
`define WRITE_GRAN 1'h1
`define VOL_PROTECT 1'h0
`define VOL_WREN_SEL 1'h0
`define UNUSED3 3'h7
`define ERASE_4K_CMD 8'h20
`define FR_112 1'h1
`define ADDR_BYTES 2'h1
`define FR_MISC 5'h1F
`define DENSITY 32'h1FFFFFFF
`define QUAD_WAIT 5'h04
`define QUAD_MODE 3'h2
`define QUAD_CMD 8'hEB
`define SINGLE_ADDR_WAIT 5'h08
`define ZERO_MODE 3'h0
`define QO_CMD 8'h6B
`define DO_CMD 8'h3B
`define WAIT_NONE 5'h00
`define DIO_MODE 3'h4
`define DIO_CMD 8'hBB
`define FR_222 1'h0
`define FR_444 1'h1
`define CMD_ABSENT 8'hFF
`define SIZE_ABSENT 8'h00
`define ET1_SIZE 8'h0C
`define ET2_SIZE 8'h0F
`define ET2_CMD 8'h52
`define ET3_SIZE 8'h10
`define ET4_SIZE_LB 8'h12
`define BLOCK_ERASE_CMD 8'hD8
`define ERASE_MULT 4'h2
`define ET1_CNT 5'h06
`define ET2_CNT 5'h08
`define ET3_CNT 5'h0A
`define ET4_CNT_LB 5'h05
`define UNIT_16MS 2'h1
`define UNIT_NONE 2'h0
`endif

// ==== hdl/param_table_pkg.sv ====
// Types shared by the parameter table store
package param_table_pkg;
  typedef enum logic [1:0] {wr_idle = 2'b01, wr_resp = 2'b10} wr_state_t;
  typedef enum logic [1:0] {rd_idle = 2'b01, rd_data = 2'b10} rd_state_t;
  typedef logic [1:0] axi_resp_t;
endpackage

// ==== hdl/param_word_table.sv ====
// Word lookup of the parameter table by byte offset
`include "param_table_params.svh"
module param_word_table (
  // Build selection
  input wire logic large_block,
  // Lookup
  input wire logic [7:0] word_off,
  output logic [31:0] table_word,
  output logic table_hit
);
  // ==========================================
  // Constant store, no state
  always_comb begin
    table_hit = (word_off < `OFF_DB_END);
    case ({word_off[7:2], 2'b00})
      `OFF_PTR_WORD: table_word = {`PTR_ID_MSB, `PTR_VALUE};
      `OFF_W30: table_word = {`RESERVED_BYTE, `FR_MISC, `ADDR_BYTES, `FR_112,
        `ERASE_4K_CMD, `UNUSED3, `VOL_WREN_SEL, `VOL_PROTECT,
        `WRITE_GRAN, `MIN_ERASE_4K};
      `OFF_W34: table_word = `DENSITY;
      `OFF_W38: table_word = {`QO_CMD, `ZERO_MODE, `SINGLE_ADDR_WAIT,
        `QUAD_CMD, `QUAD_MODE, `QUAD_WAIT};
      `OFF_W3C: table_word = {`DIO_CMD, `DIO_MODE, `WAIT_NONE,
        `DO_CMD, `ZERO_MODE, `SINGLE_ADDR_WAIT};
      `OFF_W40: table_word = {{3{`RESERVED_BYTE}}, `UNUSED3, `FR_444, `UNUSED3, `FR_222};
      `OFF_W44: table_word = {`CMD_ABSENT, `ZERO_MODE, `WAIT_NONE, {2{`RESERVED_BYTE}}};
      `OFF_W48: table_word = {`QUAD_CMD, `QUAD_MODE, `QUAD_WAIT, {2{`RESERVED_BYTE}}};
      `OFF_W4C: table_word = {`ET2_CMD, `ET2_SIZE, `ERASE_4K_CMD, `ET1_SIZE};
      `OFF_W50: begin
        if (large_block) begin
          table_word = {`BLOCK_ERASE_CMD, `ET4_SIZE_LB, `CMD_ABSENT, `SIZE_ABSENT};
        end else begin
          table_word = {`CMD_ABSENT, `SIZE_ABSENT, `BLOCK_ERASE_CMD, `ET3_SIZE};
        end
      end
      `OFF_W54: begin
        if (large_block) begin
          table_word = {`UNIT_16MS, `ET4_CNT_LB, `UNIT_NONE, `WAIT_NONE,
            `UNIT_16MS, `ET2_CNT, `UNIT_16MS, `ET1_CNT, `ERASE_MULT};
        end else begin
          table_word = {`UNIT_NONE, `WAIT_NONE, `UNIT_16MS, `ET3_CNT,
            `UNIT_16MS, `ET2_CNT, `UNIT_16MS, `ET1_CNT, `ERASE_MULT};
        end
      end
      // Unlisted offsets read as all ones
      default: table_word = {4{`RESERVED_BYTE}};
    endcase
  end
endmodule

// ==== hdl/byte_lane_pick.sv ====
// Picks one byte lane out of a table word
module byte_lane_pick (
  // Word in
  input wire logic [31:0] word_in,
  input wire logic [1:0] lane,
  // Byte out
  output logic [7:0] byte_out
);
  // ==========================================
  // Lowest address is the least significant lane
  always_comb begin
    case (lane)
      2'h0: byte_out = word_in[7:0];
      2'h1: byte_out = word_in[15:8];
      2'h2: byte_out = word_in[23:16];
      default: byte_out = word_in[31:24];
    endcase
  end
endmodule

// ==== hdl/sfdp_basic_param_rom.sv ====
// AXI4-Lite slave serving the basic flash parameter table
`include "param_table_params.svh"
module sfdp_basic_param_rom
  import param_table_pkg::*;
#(
  parameter bit LARGE_BLOCK = 1'b0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Write address channel
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  // Write data channel
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // Write response channel
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // Read address channel
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  // Read data channel
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);
  // ==========================================
  // Decode helpers
  function automatic logic in_table(input logic [7:0] a);
    in_table = (a < `OFF_DB_END);
  endfunction

  function automatic logic in_ctrl(input logic [7:0] a);
    in_ctrl = (a == `OFF_BYTE_ADDR) || (a == `OFF_BYTE_DATA) ||
              (a == `OFF_REJECT_CNT) || (a == `OFF_VARIANT);
  endfunction

  function automatic axi_resp_t wr_resp_of(input logic [7:0] a);
    if (a == `OFF_BYTE_ADDR || a == `OFF_REJECT_CNT) begin
      wr_resp_of = `RESP_OKAY;
    end else if (in_table(a) || in_ctrl(a)) begin
      wr_resp_of = `RESP_SLVERR;
    end else begin
      wr_resp_of = `RESP_DECERR;
    end
  endfunction

  // ==========================================
  // State
  wr_state_t wr_state_reg;
  rd_state_t rd_state_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  axi_resp_t bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  axi_resp_t rresp_reg;
  logic aw_got_reg;
  logic w_got_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic [6:0] byte_addr_reg;
  logic [15:0] reject_cnt_reg;

  logic aw_take;
  logic w_take;
  logic ar_take;
  logic b_done;
  logic r_done;
  logic wr_commit;
  axi_resp_t commit_resp;
  logic [31:0] bus_word;
  logic bus_hit;
  logic [31:0] ptr_word;
  logic [7:0] ptr_byte;
  logic [31:0] rd_word;
  axi_resp_t rd_resp;

  assign aw_take = awvalid && awready_reg;
  assign w_take = wvalid && wready_reg;
  assign ar_take = arvalid && arready_reg;
  assign b_done = bvalid_reg && bready;
  assign r_done = rvalid_reg && rready;
  assign wr_commit = (wr_state_reg == wr_idle) && aw_got_reg && w_got_reg;
  assign commit_resp = wr_resp_of(aw_addr_reg);

  // ==========================================
  // Table lookups: one for the bus, one for the byte window
  param_word_table bus_table (
    .large_block(LARGE_BLOCK),
    .word_off(araddr),
    .table_word(bus_word),
    .table_hit(bus_hit)
  );

  param_word_table byte_table (
    .large_block(LARGE_BLOCK),
    .word_off({1'b0, byte_addr_reg[6:2], 2'b00}),
    .table_word(ptr_word),
    .table_hit()
  );

  byte_lane_pick byte_pick (
    .word_in(ptr_word),
    .lane(byte_addr_reg[1:0]),
    .byte_out(ptr_byte)
  );

  // ==========================================
  // Read data mux
  always_comb begin
    rd_word = 32'h00000000;
    rd_resp = `RESP_OKAY;
    if (bus_hit) begin
      rd_word = bus_word;
    end else if (araddr == `OFF_BYTE_ADDR) begin
      rd_word = {25'h0000000, byte_addr_reg};
    end else if (araddr == `OFF_BYTE_DATA) begin
      rd_word = {24'h000000, ptr_byte};
    end else if (araddr == `OFF_REJECT_CNT) begin
      rd_word = {16'h0000, reject_cnt_reg};
    end else if (araddr == `OFF_VARIANT) begin
      rd_word = {31'h00000000, LARGE_BLOCK};
    end else begin
      rd_resp = `RESP_DECERR;
    end
  end

  // ==========================================
  // Write address capture
  // Ready drops once taken so a second address cannot overrun the first
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      awready_reg <= 1'b0;
      aw_got_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (aw_take) begin
      awready_reg <= 1'b0;
      aw_got_reg <= 1'b1;
      aw_addr_reg <= awaddr;
    end else if (b_done) begin
      awready_reg <= 1'b1;
      aw_got_reg <= 1'b0;
    end else if (!aw_got_reg) begin
      awready_reg <= 1'b1;
    end
  end

  // ==========================================
  // Write data capture
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wready_reg <= 1'b0;
      w_got_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else if (w_take) begin
      wready_reg <= 1'b0;
      w_got_reg <= 1'b1;
      w_data_reg <= wdata;
      w_strb_reg <= wstrb;
    end else if (b_done) begin
      wready_reg <= 1'b1;
      w_got_reg <= 1'b0;
    end else if (!w_got_reg) begin
      wready_reg <= 1'b1;
    end
  end

  // ==========================================
  // Write response
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_state_reg <= wr_idle;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
    end else begin
      unique case (wr_state_reg)
        wr_idle: begin
          if (wr_commit) begin
            wr_state_reg <= wr_resp;
            bvalid_reg <= 1'b1;
            bresp_reg <= commit_resp;
          end
        end
        wr_resp: begin
          if (b_done) begin
            wr_state_reg <= wr_idle;
            bvalid_reg <= 1'b0;
          end
        end
      endcase
    end
  end

  // ==========================================
  // Read channel
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_state_reg <= rd_idle;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `RESP_OKAY;
    end else begin
      unique case (rd_state_reg)
        rd_idle: begin
          if (ar_take) begin
            rd_state_reg <= rd_data;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_word;
            rresp_reg <= rd_resp;
          end else begin
            arready_reg <= 1'b1;
          end
        end
        rd_data: begin
          if (r_done) begin
            rd_state_reg <= rd_idle;
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
          end
        end
      endcase
    end
  end

  // ==========================================
  // Byte window pointer
  // Each data read below 7Fh steps to the next byte, like a serial stream
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      byte_addr_reg <= `BYTE_ADDR_RST;
    end else if (wr_commit && aw_addr_reg == `OFF_BYTE_ADDR && w_strb_reg[0]) begin
      byte_addr_reg <= w_data_reg[6:0];
    end else if (ar_take && araddr == `OFF_BYTE_DATA && byte_addr_reg != `BYTE_ADDR_MAX) begin
      byte_addr_reg <= byte_addr_reg + 7'h01;
    end
  end

  // ==========================================
  // Refused write counter, saturates
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reject_cnt_reg <= 16'h0000;
    end else if (wr_commit && aw_addr_reg == `OFF_REJECT_CNT && w_strb_reg[0]) begin
      reject_cnt_reg <= 16'h0000;
    end else if (wr_commit && commit_resp != `RESP_OKAY && reject_cnt_reg != `REJECT_MAX) begin
      reject_cnt_reg <= reject_cnt_reg + 16'h0001;
    end
  end

  // ==========================================
  // Outputs
  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

  // ==========================================
  // Checks
  default clocking chk_cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  sequence rd_at(logic [7:0] a);
    arvalid && arready_reg && araddr == a;
  endsequence

  sequence answer_ok;
    rvalid_reg && rresp_reg == `RESP_OKAY;
  endsequence

  chk_ptr_word: assert property (rd_at(`OFF_PTR_WORD) |=> answer_ok
    ##0 rdata_reg[23:0] == `PTR_VALUE) else $error("table pointer wrong");
  chk_first_byte: assert property (rd_at(`OFF_W30) |=> answer_ok
    ##0 rdata_reg[1:0] == `MIN_ERASE_4K && rdata_reg[2] && rdata_reg[7:5] == `UNUSED3)
    else $error("byte 30h fields wrong");
  chk_vol_bits: assert property (rd_at(`OFF_W30) |=> rdata_reg[4:3] == 2'h0)
    else $error("volatile bits not zero");
  chk_read_modes: assert property (rd_at(`OFF_W30) |=> rdata_reg[16] &&
    rdata_reg[18:17] == `ADDR_BYTES && rdata_reg[23:19] == `FR_MISC &&
    rdata_reg[15:8] == `ERASE_4K_CMD) else $error("byte 31h-32h wrong");
  chk_density: assert property (rd_at(`OFF_W34) |=> answer_ok ##0 rdata_reg == `DENSITY)
    else $error("density wrong");
  chk_quad_io: assert property (rd_at(`OFF_W38) |=> rdata_reg[4:0] == `QUAD_WAIT &&
    rdata_reg[7:5] == `QUAD_MODE && rdata_reg[15:8] == `QUAD_CMD)
    else $error("quad io descriptor wrong");
  chk_quad_out: assert property (rd_at(`OFF_W38) |=> rdata_reg[31:24] == `QO_CMD &&
    rdata_reg[20:16] == `SINGLE_ADDR_WAIT && rdata_reg[23:21] == `ZERO_MODE)
    else $error("quad output descriptor wrong");
  chk_dual_out: assert property (rd_at(`OFF_W3C) |=> rdata_reg[15:8] == `DO_CMD &&
    rdata_reg[4:0] == `SINGLE_ADDR_WAIT && rdata_reg[7:5] == `ZERO_MODE)
    else $error("dual output descriptor wrong");
  chk_dual_io: assert property (rd_at(`OFF_W3C) |=> rdata_reg[31:24] == `DIO_CMD &&
    rdata_reg[23:21] == `DIO_MODE && rdata_reg[20:16] == `WAIT_NONE)
    else $error("dual io descriptor wrong");
  chk_all_mode_flags: assert property (rd_at(`OFF_W40) |=> !rdata_reg[0] &&
    rdata_reg[4] && rdata_reg[31:5] == 27'h7FFFFFF && rdata_reg[3:1] == `UNUSED3)
    else $error("all-mode flags wrong");
  chk_dual_all_off: assert property (rd_at(`OFF_W44) |=> rdata_reg[31:16] == 16'hFF00)
    else $error("all-dual descriptor wrong");
  chk_quad_all: assert property (rd_at(`OFF_W48) |=> rdata_reg[31:24] == `QUAD_CMD &&
    rdata_reg[20:16] == `QUAD_WAIT && rdata_reg[23:21] == `QUAD_MODE)
    else $error("all-quad descriptor wrong");
  chk_erase_small: assert property (rd_at(`OFF_W4C) |=> rdata_reg[7:0] == `ET1_SIZE &&
    rdata_reg[15:8] == `ERASE_4K_CMD && rdata_reg[31:16] == {`ET2_CMD, `ET2_SIZE})
    else $error("erase types 1-2 wrong");
  chk_erase_large: assert property (rd_at(`OFF_W50) |=> rdata_reg[15:0] == (LARGE_BLOCK ?
    {`CMD_ABSENT, `SIZE_ABSENT} : {`BLOCK_ERASE_CMD, `ET3_SIZE}) &&
    rdata_reg[31:16] == (LARGE_BLOCK ? {`BLOCK_ERASE_CMD, `ET4_SIZE_LB} :
    {`CMD_ABSENT, `SIZE_ABSENT})) else $error("erase types 3-4 wrong");
  chk_erase_mult: assert property (rd_at(`OFF_W54) |=> rdata_reg[3:0] == `ERASE_MULT &&
    rdata_reg[10:4] == {`UNIT_16MS, `ET1_CNT} &&
    rdata_reg[17:11] == {`UNIT_16MS, `ET2_CNT})
    else $error("erase time 1-2 wrong");
  chk_erase_times: assert property (rd_at(`OFF_W54) |=> rdata_reg[31:18] == (LARGE_BLOCK ?
    {`UNIT_16MS, `ET4_CNT_LB, `UNIT_NONE, `WAIT_NONE} :
    {`UNIT_NONE, `WAIT_NONE, `UNIT_16MS, `ET3_CNT})) else $error("erase time 3-4 wrong");
  chk_table_no_write: assert property (wr_commit && in_table(aw_addr_reg) |=>
    bvalid_reg && bresp_reg == `RESP_SLVERR &&
    (reject_cnt_reg == $past(reject_cnt_reg) + 16'h0001 ||
    $past(reject_cnt_reg) == `REJECT_MAX))
    else $error("table write not refused");
  chk_resp_hold: assert property (rvalid_reg && !rready |=> rvalid_reg && $stable(rdata_reg))
    else $error("read answer dropped");
  chk_byte_order: assert property (rd_at(`OFF_BYTE_DATA) && byte_addr_reg == 7'h31 |=>
    rdata_reg == {24'h000000, `ERASE_4K_CMD}) else $error("byte lane order wrong");
endmodule

// ==== testbench/param_host_model.sv ====
// Register bus host model that reads and writes the parameter table store
module param_host_model
  import param_table_pkg::*;
#(
  parameter int LIMIT = 200
) (
  // Clock
  input wire logic ref_clk,
  // Write channels
  output logic awvalid,
  input wire logic awready,
  output logic [7:0] awaddr,
  output logic [2:0] awprot,
  output logic wvalid,
  input wire logic wready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  input wire logic bvalid,
  output logic bready,
  // Read channels
  output logic arvalid,
  input wire logic arready,
  output logic [7:0] araddr,
  output logic [2:0] arprot,
  input wire logic rvalid,
  output logic rready,
  // Wait ran out
  output logic hang
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, hang} = 6'h00;
    {awaddr, araddr, awprot, arprot, wstrb} = 26'h0000000;
    wdata = 32'h00000000;
  end
  // ==========================================
  // Read: payload inverted once released, so stale values never match
  task automatic axi_read(input logic [7:0] addr, input int stall);
    int n;
    n = 0;
    arvalid <= 1'b1;
    araddr <= addr;
    arprot <= 3'($urandom_range(0, 7));
    do begin
      @(posedge ref_clk);
      n++;
    end while (!arready && n < LIMIT);
    arvalid <= 1'b0;
    araddr <= ~addr;
    do begin
      if (n >= stall) rready <= 1'b1;
      @(posedge ref_clk);
      n++;
    end while (!(rvalid && rready) && n < LIMIT);
    rready <= 1'b0;
    if (n >= LIMIT) hang <= 1'b1;
  endtask
  // ==========================================
  // Write: address and data offered together, each released when taken
  task automatic axi_write(input logic [7:0] addr, input logic [31:0] data,
      input logic [3:0] strb, input int stall);
    int n;
    bit aw_done;
    bit w_done;
    n = 0;
    aw_done = 1'b0;
    w_done = 1'b0;
    awvalid <= 1'b1;
    awaddr <= addr;
    awprot <= 3'($urandom_range(0, 7));
    wvalid <= 1'b1;
    wdata <= data;
    wstrb <= strb;
    do begin
      @(posedge ref_clk);
      n++;
      if (!aw_done && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
        awaddr <= ~addr;
      end
      if (!w_done && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
        wdata <= ~data;
      end
    end while (!(aw_done && w_done) && n < LIMIT);
    do begin
      if (n >= stall) bready <= 1'b1;
      @(posedge ref_clk);
      n++;
    end while (!(bvalid && bready) && n < LIMIT);
    bready <= 1'b0;
    if (n >= LIMIT) hang <= 1'b1;
  endtask
endmodule

// ==== testbench/testbench.sv ====
// Self-checking bench for the parameter table store in both builds
`include "param_table_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import param_table_pkg::*;
  typedef struct {
    logic [31:0] data;
    logic [31:0] mask;
    axi_resp_t resp;
  } note_t;
  logic ref_clk;
  logic sys_rst;
  int err_count;
  int tests_run;
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // ==========================================
  // One store per build, each with its host and watcher
  for (genvar g = 0; g < 2; g++) begin : build
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, hang;
    logic [7:0] awaddr, araddr;
    logic [2:0] awprot, arprot;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    note_t rd_q[$];
    note_t wr_q[$];
    note_t rn, wn;
    sfdp_basic_param_rom #(.LARGE_BLOCK(g == 1)) i_sfdp_basic_param_rom (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .awprot(awprot), .wvalid(wvalid), .wready(wready), .wdata(wdata),
      .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .arprot(arprot), .rvalid(rvalid),
      .rready(rready), .rdata(rdata), .rresp(rresp));
    param_host_model host (
      .ref_clk(ref_clk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .awprot(awprot), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .arprot(arprot), .rvalid(rvalid), .rready(rready), .hang(hang));
    always @(posedge ref_clk) begin
      if (!sys_rst && rvalid && rready) begin
        rn = rd_q.pop_front();
        check({rresp, rdata & rn.mask}, {rn.resp, rn.data & rn.mask});
      end
      if (!sys_rst && bvalid && bready) begin
        wn = wr_q.pop_front();
        check({32'h00000000, bresp}, {32'h00000000, wn.resp});
      end
    end
  end
  always @(posedge ref_clk) begin
    if (build[0].hang === 1'b1 || build[1].hang === 1'b1) begin
      err_count++;
      results();
    end
  end
  // ==========================================
  // Checking and reporting
  task automatic check(input logic [33:0] seen, input logic [33:0] expv);
    tests_run++;
    if (seen !== expv) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, expv);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic endtest(input string name);
    $display("test %s finished at %0t", name, $time);
  endtask
  function automatic note_t mk(input logic [31:0] d, input logic [31:0] m, input axi_resp_t r);
    note_t n;
    n.data = d;
    n.mask = m;
    n.resp = r;
    return n;
  endfunction
  // Expected word per address, low two bits ignored for the table
  function automatic note_t table_note(input bit lb, input logic [7:0] a);
    note_t n;
    n = mk(32'hFFFFFFFF, 32'hFFFFFFFF, `RESP_OKAY);
    case (a & 8'hFC)
      8'h0C: n.data = 32'hFF000030;
      8'h30: n.data = 32'hFFFB20E5;
      8'h34: n.data = 32'h1FFFFFFF;
      8'h38: n.data = 32'h6B08EB44;
      8'h3C: n.data = 32'hBB803B08;
      8'h40: n.data = 32'hFFFFFFFE;
      8'h44: n.data = 32'hFF00FFFF;
      8'h48: n.data = 32'hEB44FFFF;
      8'h4C: n.data = 32'h520F200C;
      8'h50: n.data = lb ? 32'hD812FF00 : 32'hFF00D810;
      8'h54: n.data = lb ? 32'h4A014262 : 32'h00A94262;
      8'h8C: n.data = {31'h00000000, lb};
      default: if (a >= 8'h58) n = mk(32'h00000000, 32'hFFFFFFFF, `RESP_DECERR);
    endcase
    return n;
  endfunction
  task automatic rd(input int b, input logic [7:0] a, input note_t n);
    int stall;
    stall = $urandom_range(0, 3);
    if (b == 0) begin
      build[0].rd_q.push_back(n);
      build[0].host.axi_read(a, stall);
    end else begin
      build[1].rd_q.push_back(n);
      build[1].host.axi_read(a, stall);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
      input axi_resp_t r);
    build[0].wr_q.push_back(mk(32'h00000000, 32'h00000000, r));
    build[0].host.axi_write(a, d, s, $urandom_range(0, 3));
  endtask
  // ==========================================
  // Main sequence
  initial begin
    logic [7:0] a;
    logic [7:0] p;
    note_t t;
    err_count = 0;
    tests_run = 0;
    sys_rst = 1'b1;
    void'($urandom(19342));
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    for (int b = 0; b < 2; b++) begin
      for (int w = 8'h30; w < 8'h58; w += 4) begin
        a = 8'(w) | 8'($urandom_range(0, 3));
        rd(b, a, table_note(b[0], a));
      end
      rd(b, 8'h0C, table_note(b[0], 8'h0C));
      rd(b, 8'h8C, table_note(b[0], 8'h8C));
    end
    endtest("table words");
    wr(8'h88, 32'h00000000, 4'h1, `RESP_OKAY);
    wr(8'h30, 32'h00000000, 4'hF, `RESP_SLVERR);
    wr(8'h84, 32'h00000000, 4'hF, `RESP_SLVERR);
    wr(8'h8C, 32'h00000001, 4'hF, `RESP_SLVERR);
    wr(8'hA0, 32'h00000000, 4'hF, `RESP_DECERR);
    rd(0, 8'h88, mk(32'h00000004, 32'h0000FFFF, `RESP_OKAY));
    rd(0, 8'h30, table_note(1'b0, 8'h30));
    rd(0, 8'h8C, table_note(1'b0, 8'h8C));
    endtest("refused writes");
    // Byte window: assembled low address first
    p = 8'h30 + 8'($urandom_range(0, 37));
    wr(8'h80, {24'h000000, p}, 4'h1, `RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      a = p + 8'(i);
      t = table_note(1'b0, a);
      t.data = t.data >> (8 * a[1:0]);
      t.mask = 32'h000000FF;
      rd(0, 8'h84, t);
    end
    wr(8'h80, 32'h00000031, 4'h0, `RESP_OKAY);
    rd(0, 8'h80, mk({24'h000000, p + 8'h03}, 32'h0000007F, `RESP_OKAY));
    // Fixed pointer so the lane order check always fires once
    wr(8'h80, 32'h00000031, 4'h1, `RESP_OKAY);
    rd(0, 8'h84, mk({24'h000000, `ERASE_4K_CMD}, 32'h000000FF, `RESP_OKAY));
    endtest("byte window");
    fork
      rd(0, 8'h4C, table_note(1'b0, 8'h4C));
      wr(8'h50, 32'h00000000, 4'hF, `RESP_SLVERR);
    join
    rd(0, 8'h50, table_note(1'b0, 8'h50));
    endtest("overlapped read and write");
    for (int k = 0; k < 60; k++) begin
      a = 8'($urandom_range(0, 255));
      if (a[7:4] == 4'h8) a = 8'h8C;
      rd(k % 2, a, table_note(k[0], a));
    end
    endtest("random reads");
    repeat (3) @(posedge ref_clk);
    check(34'(build[0].rd_q.size() + build[1].rd_q.size() + build[0].wr_q.size()), 34'h0);
    results();
  end
endmodule
